// ==== scmr_link_partner.sv ====
// Far-side link model: answers a forwarded request with a tagged response.
// Assumes decisions on I_CLK_SYS; answer delay is set by the bench.
`timescale 1ns/1ps
module scmr_link_partner (
  input  wire logic                i_clk,
  input  wire logic                i_rst_b,
  input  wire scmr_pkg::scmr_dec_t i_dec,
  input  wire logic [7:0]          i_delay,
  output scmr_pkg::scmr_rsp_t      o_rsp
);
  logic       held;
  logic [1:0] port;
  logic [1:0] gen;
  logic [7:0] cnt;

  // One request in flight; idle lines toggle so stale values never look valid
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      held <= 1'b0;
      port <= 2'h0;
      gen <= 2'h0;
      cnt <= 8'h00;
      o_rsp <= '0;
    end else begin
      o_rsp <= '{1'b0, ~o_rsp.port, ~o_rsp.gen};
      // Answers only forwarded requests and never issues requests itself
      if (!held && i_dec.valid && i_dec.act == scmr_pkg::A_FORWARD) begin
        held <= 1'b1;
        port <= i_dec.port;
        gen <= i_dec.gen;
        cnt <= i_delay;
      end else if (held && cnt != 8'h00) begin
        cnt <= cnt - 8'h01;
      end else if (held) begin
        o_rsp <= '{1'b1, port, gen};
        held <= 1'b0;
      end
    end
  end
endmodule

// ==== scmr_pkg.sv ====
// Constants and carrier types for the switch routing decision block.
// Assumes a four-port switch with the link logic around it supplying packets.
package scmr_pkg;

  localparam int NPORT = 4;
  localparam int PW    = 2;

  // Register map: one 16-byte window per port, port index in paddr[5:4]
  localparam int         ADDR_PORT_LSB = 4;
  localparam logic [1:0] ADDR_TOP_FREE = 2'h0;
  localparam logic [3:0] OFF_BUS       = 4'h0;
  localparam logic [3:0] OFF_CTRL      = 4'h4;
  localparam logic [3:0] OFF_STAT      = 4'h8;

  // Bus word fields
  localparam int F_PRI  = 0;
  localparam int F_SEC  = 8;
  localparam int F_SUB  = 16;
  localparam int F_UNIT = 24;

  // Control word fields
  localparam int C_CONCEAL  = 0;
  localparam int C_UCFG     = 1;
  localparam int C_ABSEL    = 2;
  localparam int C_FLOOD    = 3;
  localparam int C_FATAL    = 4;
  localparam int C_NONFATAL = 5;
  localparam int C_SERR     = 6;
  localparam int C_PRIMARY  = 7;
  localparam int C_DPORT    = 8;
  localparam int C_COMPAT   = 10;
  localparam int C_PMASK    = 12;

  // Status word fields; bits 0..5 are write-one-to-clear
  localparam int S_PRI_UNCL = 0;
  localparam int S_SEC_UNCL = 1;
  localparam int S_PRI_STA  = 2;
  localparam int S_SEC_STA  = 3;
  localparam int S_SYSERR   = 4;
  localparam int S_EOC      = 5;
  localparam int S_W        = 6;

  // Values after reset
  localparam logic [31:0]    BUS_RST  = 32'h0000_0000;
  localparam logic [31:0]    CTRL_RST = 32'h0000_f000;
  localparam logic [S_W-1:0] STAT_RST = 6'h00;

  typedef enum logic [2:0] {
    K_CFG0, K_CFG1, K_MSG0, K_MSG1, K_INTR, K_INTERRUPT_ACKNOWLEDGE_REQUEST, K_SMGT, K_OTHER
  } scmr_kind_t;

  typedef enum logic [3:0] {
    A_NONE, A_ACCESS, A_FORWARD, A_REFLECT, A_DELIVER,
    A_MABORT, A_TABORT, A_ONES, A_DROP, A_REJECT
  } scmr_act_t;

  typedef struct packed {
    logic          valid;
    logic [PW-1:0] port;
    scmr_kind_t    kind;
    logic [7:0]    bus;
    logic [4:0]    dev;
    logic          lw;
    logic [1:0]    lw_idx;
    logic          lw_level;
  } scmr_req_t;

  typedef struct packed {
    logic          valid;
    scmr_act_t     act;
    logic [PW-1:0] port;
    logic          to_type0;
    logic          flood;
    logic          fatal_irq;
    logic          nonfatal_irq;
    logic [1:0]    gen;
  } scmr_dec_t;

  typedef struct packed {
    logic          valid;
    logic [PW-1:0] port;
    logic [1:0]    gen;
  } scmr_rsp_t;

  typedef struct packed {
    logic          valid;
    logic [PW-1:0] port;
    logic          drop;
  } scmr_rspo_t;

endpackage

// ==== scmr_router.sv ====
// Routing decision core: configuration, message, interrupt and
// management packets, per-port link wake and inactive-port isolation.
// Assumes packets arrive one per cycle from link logic on I_CLK_SYS;
// port status lines and link stop come from outside and are synchronised.
`timescale 1ns/1ps

module scmr_router (
  input  wire logic                       I_CLK_SYS,
  input  wire logic                       I_RST_B,
  input  wire logic                       I_PSEL,
  input  wire logic                       I_PENABLE,
  input  wire logic                       I_PWRITE,
  input  wire logic [7:0]                 I_PADDR,
  input  wire logic [31:0]                I_PWDATA,
  output logic      [31:0]                O_PRDATA,
  output logic                            O_PREADY,
  output logic                            O_PSLVERR,
  input  wire scmr_pkg::scmr_req_t        I_REQ,
  output scmr_pkg::scmr_dec_t             O_DEC,
  input  wire scmr_pkg::scmr_rsp_t        I_RSP,
  output scmr_pkg::scmr_rspo_t            O_RSP,
  input  wire logic [3:0]                 I_LINK_STOP,
  input  wire logic [3:0]                 I_PORT_INACTIVE,
  input  wire logic [3:0]                 I_LOCAL_FN,
  output logic      [3:0]                 O_LINK_WAKE,
  output logic      [3:0][3:0]            O_LEGACY_WIRE
);

  localparam int N = scmr_pkg::NPORT;

  // Configuration and status state
  logic [31:0]                bus_reg      [N];
  logic [31:0]                ctrl_reg     [N];
  logic [scmr_pkg::S_W-1:0]   stat         [N];
  logic [31:0]                next_bus     [N];
  logic [31:0]                next_ctrl    [N];
  logic [scmr_pkg::S_W-1:0]   next_stat    [N];
  logic [scmr_pkg::S_W-1:0]   sset         [N];
  logic [N-1:0][3:0]          lwst;
  logic [N-1:0][3:0]          next_lwst;
  logic [N-1:0][1:0]          gen;
  logic [N-1:0][1:0]          next_gen;
  logic [N-1:0]               wake;
  logic [N-1:0]               next_wake;
  logic [N-1:0][3:0]          next_lw_out;

  // Synchronisers for outside levels
  logic [N-1:0]               stop_m;
  logic [N-1:0]               stop_s;
  logic [N-1:0]               inact_m;
  logic [N-1:0]               inact_s;
  logic [N-1:0]               inact_q;

  // Bus slave
  logic [1:0]                 a_port;
  logic [3:0]                 a_off;
  logic                       a_map;
  logic                       a_setup;
  logic                       a_wr;
  logic [31:0]                rd_mux;
  logic [31:0]                next_prdata;
  logic                       next_pready;
  logic                       next_pslverr;

  // Routing
  scmr_pkg::scmr_dec_t        rd;
  scmr_pkg::scmr_rspo_t       next_rsp;
  logic [N-1:0]               hit;
  logic [31:0]                cb;
  logic [1:0]                 ip;
  logic [1:0]                 dp;
  logic [1:0]                 mp;
  logic [1:0]                 eg;
  logic [2:0]                 nm;
  logic [N-1:0]               pm;
  logic                       ds;
  logic                       msg;
  logic                       unit_hit;
  logic                       dev_ok;
  logic                       uncl;
  logic                       want_acc;
  logic                       eoc;

  // Two flops before any logic looks at outside levels
  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      stop_m  <= '0;
      stop_s  <= '0;
      inact_m <= '0;
      inact_s <= '0;
      inact_q <= '0;
    end else begin
      stop_m  <= I_LINK_STOP;
      stop_s  <= stop_m;
      inact_m <= I_PORT_INACTIVE;
      inact_s <= inact_m;
      inact_q <= inact_s;
    end
  end

  // Range match of the request bus against every port
  always_comb begin
    for (int p = 0; p < N; p++) begin
      hit[p] = (I_REQ.bus >= bus_reg[p][scmr_pkg::F_SEC+:8]) &&
               (I_REQ.bus <= bus_reg[p][scmr_pkg::F_SUB+:8]);
    end
  end

  // Secondary ports of the ingress partition whose range holds the bus
  always_comb begin
    nm = 3'h0;
    mp = 2'h0;
    for (int p = 0; p < N; p++) begin
      if (pm[p] && !ctrl_reg[p][scmr_pkg::C_PRIMARY] && hit[p]) begin
        nm = nm + 3'h1;
        mp = p[1:0];
      end
    end
  end

  // Routing decision for the packet in this cycle
  always_comb begin
    ip       = I_REQ.port;
    cb       = ctrl_reg[ip];
    ds       = cb[scmr_pkg::C_PRIMARY];
    dp       = cb[scmr_pkg::C_DPORT+:2];
    pm       = cb[scmr_pkg::C_PMASK+:4];
    msg      = (I_REQ.kind == scmr_pkg::K_MSG0) || (I_REQ.kind == scmr_pkg::K_MSG1);
    unit_hit = I_REQ.dev == bus_reg[ip][scmr_pkg::F_UNIT+:5];
    dev_ok   = (I_REQ.dev < 5'(N)) && pm[I_REQ.dev[1:0]];
    uncl     = 1'b0;
    want_acc = 1'b0;
    eoc      = 1'b0;
    eg       = ip;
    rd       = '0;
    rd.valid = I_REQ.valid;
    for (int p = 0; p < N; p++) begin
      sset[p] = '0;
    end
    case (I_REQ.kind)
      scmr_pkg::K_CFG0, scmr_pkg::K_MSG0: begin
        // Downstream needs only the unit match; upstream also visibility
        if (unit_hit && (ds || (!cb[scmr_pkg::C_CONCEAL] && (msg || cb[scmr_pkg::C_UCFG])))) begin
          want_acc = 1'b1;
        end else if (msg) begin
          eoc = 1'b1;
        end else begin
          rd.act = scmr_pkg::A_MABORT;
        end
      end
      scmr_pkg::K_CFG1, scmr_pkg::K_MSG1: begin
        if (ds) begin
          if (!hit[ip]) begin
            if (msg) begin
              eoc = 1'b1;
            end else begin
              rd.act = scmr_pkg::A_MABORT;
            end
          end else if (I_REQ.bus == bus_reg[ip][scmr_pkg::F_SEC+:8]) begin
            if (dev_ok) begin
              want_acc = 1'b1;
              eg       = I_REQ.dev[1:0];
            end else begin
              uncl = 1'b1;
            end
          end else if (nm != 3'h1) begin
            uncl = 1'b1;
          end else begin
            rd.act      = scmr_pkg::A_FORWARD;
            eg          = mp;
            rd.to_type0 = I_REQ.bus == bus_reg[mp][scmr_pkg::F_SEC+:8];
          end
        end else begin
          if (I_REQ.bus == bus_reg[ip][scmr_pkg::F_SEC+:8]) begin
            // Messages never touch local state on this path
            if (!msg && unit_hit && !cb[scmr_pkg::C_CONCEAL]) begin
              want_acc = 1'b1;
            end else begin
              rd.act      = scmr_pkg::A_REFLECT;
              rd.to_type0 = 1'b1;
            end
          end else if (hit[ip]) begin
            rd.act = scmr_pkg::A_REFLECT;
          end else if (I_REQ.bus == bus_reg[ip][scmr_pkg::F_PRI+:8]) begin
            if (dev_ok) begin
              want_acc = 1'b1;
              eg       = I_REQ.dev[1:0];
            end else begin
              uncl = 1'b1;
            end
          end else if (!hit[dp]) begin
            rd.act = scmr_pkg::A_FORWARD;
            eg     = dp;
          end else if (nm != 3'h1) begin
            uncl = 1'b1;
          end else begin
            rd.act      = scmr_pkg::A_FORWARD;
            eg          = mp;
            rd.to_type0 = I_REQ.bus == bus_reg[mp][scmr_pkg::F_SEC+:8];
          end
        end
      end
      scmr_pkg::K_INTR: begin
        // Downstream interrupts are undefined and dropped here
        if (!ds) begin
          rd.act = scmr_pkg::A_FORWARD;
          eg     = dp;
        end else begin
          rd.act = scmr_pkg::A_DROP;
        end
      end
      scmr_pkg::K_INTERRUPT_ACKNOWLEDGE_REQUEST: begin
        if (ds) begin
          rd.act = scmr_pkg::A_FORWARD;
          eg     = cb[scmr_pkg::C_COMPAT+:2];
        end else begin
          rd.act = scmr_pkg::A_DROP;
        end
      end
      scmr_pkg::K_SMGT: begin
        if (!ds) begin
          rd.act = scmr_pkg::A_FORWARD;
          eg     = dp;
        end else begin
          rd.act = scmr_pkg::A_DROP;
        end
      end
      default: begin
        rd.act = scmr_pkg::A_NONE;
      end
    endcase
    // Chain end: drop and flag
    if (eoc) begin
      rd.act              = scmr_pkg::A_DROP;
      sset[ip][scmr_pkg::S_EOC] = 1'b1;
    end
    // Addressed port reached: registers or local function
    if (want_acc) begin
      if (msg) begin
        rd.act = I_LOCAL_FN[eg] ? scmr_pkg::A_DELIVER : scmr_pkg::A_DROP;
      end else begin
        rd.act = scmr_pkg::A_ACCESS;
      end
    end
    // Unclaimed: flag on the side opposite the one it arrived from, then answer
    if (uncl) begin
      sset[ip][ds ? scmr_pkg::S_SEC_UNCL : scmr_pkg::S_PRI_UNCL] = 1'b1;
      if (msg) begin
        rd.act = scmr_pkg::A_DROP;
        if (cb[scmr_pkg::C_ABSEL]) begin
          if (cb[scmr_pkg::C_FLOOD] && cb[scmr_pkg::C_SERR]) begin
            rd.flood = 1'b1;
            sset[ip][scmr_pkg::S_SYSERR] = 1'b1;
          end else if (cb[scmr_pkg::C_FATAL]) begin
            rd.fatal_irq = 1'b1;
          end else if (cb[scmr_pkg::C_NONFATAL]) begin
            rd.nonfatal_irq = 1'b1;
          end
        end
      end else if (cb[scmr_pkg::C_ABSEL]) begin
        rd.act = scmr_pkg::A_TABORT;
        sset[ip][ds ? scmr_pkg::S_PRI_STA : scmr_pkg::S_SEC_STA] = 1'b1;
      end else begin
        rd.act = scmr_pkg::A_ONES;
      end
    end
    // An inactive egress must not hold up the active ports
    if (inact_s[eg] && (rd.act == scmr_pkg::A_FORWARD || rd.act == scmr_pkg::A_REFLECT ||
                        rd.act == scmr_pkg::A_ACCESS || rd.act == scmr_pkg::A_DELIVER)) begin
      rd.act = scmr_pkg::A_REJECT;
    end
    rd.port = eg;
    rd.gen  = gen[eg];
    if (!I_REQ.valid) begin
      rd = '0;
    end
  end

  // Bus slave decode; one setup plus one access cycle
  always_comb begin
    a_port  = I_PADDR[scmr_pkg::ADDR_PORT_LSB+:2];
    a_off   = I_PADDR[3:0];
    a_map   = (I_PADDR[7:6] == scmr_pkg::ADDR_TOP_FREE) &&
              (a_off == scmr_pkg::OFF_BUS || a_off == scmr_pkg::OFF_CTRL || a_off == scmr_pkg::OFF_STAT);
    a_setup = I_PSEL && !I_PENABLE;
    a_wr    = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && a_map;
    case (a_off)
      scmr_pkg::OFF_BUS:  rd_mux = bus_reg[a_port];
      scmr_pkg::OFF_CTRL: rd_mux = ctrl_reg[a_port];
      scmr_pkg::OFF_STAT: rd_mux = {24'h0, stop_s[a_port], inact_s[a_port], stat[a_port]};
      default:            rd_mux = 32'h0;
    endcase
    next_pready  = a_setup;
    next_pslverr = a_setup && !a_map;
    next_prdata  = (a_setup && !I_PWRITE && a_map) ? rd_mux : 32'h0;
  end

  // Register, status, wake, generation and legacy wire next values
  always_comb begin
    for (int p = 0; p < N; p++) begin
      next_bus[p]  = bus_reg[p];
      next_ctrl[p] = ctrl_reg[p];
      next_stat[p] = stat[p];
      if (a_wr && a_port == p[1:0] && a_off == scmr_pkg::OFF_BUS) begin
        next_bus[p] = I_PWDATA;
      end
      if (a_wr && a_port == p[1:0] && a_off == scmr_pkg::OFF_CTRL) begin
        next_ctrl[p] = I_PWDATA;
      end
      if (a_wr && a_port == p[1:0] && a_off == scmr_pkg::OFF_STAT) begin
        next_stat[p] = stat[p] & ~I_PWDATA[scmr_pkg::S_W-1:0];
      end
      // Set beats a clear landing in the same cycle
      next_stat[p] = next_stat[p] | (I_REQ.valid ? sset[p] : '0);
      // Entering reset (port going inactive) retires every outstanding tag of that port
      next_gen[p]  = (inact_s[p] && !inact_q[p]) ? gen[p] + 2'h1 : gen[p];
      // Wake held until the stopped link comes back
      next_wake[p] = stop_s[p] && (wake[p] || (rd.port == p[1:0] && rd.act == scmr_pkg::A_FORWARD));
      next_lwst[p] = lwst[p];
      if (I_REQ.valid && I_REQ.kind == scmr_pkg::K_SMGT && I_REQ.lw && I_REQ.port == p[1:0] &&
          !ctrl_reg[p][scmr_pkg::C_PRIMARY]) begin
        next_lwst[p][I_REQ.lw_idx] = I_REQ.lw_level;
      end
    end
    // Each primary port ORs the wires of the secondaries behind it
    for (int p = 0; p < N; p++) begin
      next_lw_out[p] = 4'h0;
      for (int q = 0; q < N; q++) begin
        if (!ctrl_reg[q][scmr_pkg::C_PRIMARY] && ctrl_reg[q][scmr_pkg::C_DPORT+:2] == p[1:0]) begin
          next_lw_out[p] = next_lw_out[p] | lwst[q];
        end
      end
    end
  end

  // Responses to a port that went inactive since the request are stale
  always_comb begin
    next_rsp       = '0;
    next_rsp.valid = I_RSP.valid;
    next_rsp.port  = I_RSP.port;
    next_rsp.drop  = I_RSP.valid && (inact_s[I_RSP.port] || I_RSP.gen != gen[I_RSP.port]);
  end

  always_ff @(posedge I_CLK_SYS or negedge I_RST_B) begin
    if (!I_RST_B) begin
      for (int p = 0; p < N; p++) begin
        bus_reg[p]  <= scmr_pkg::BUS_RST;
        ctrl_reg[p] <= scmr_pkg::CTRL_RST;
        stat[p]     <= scmr_pkg::STAT_RST;
      end
      gen           <= '0;
      wake          <= '0;
      lwst          <= '0;
      O_LINK_WAKE   <= '0;
      O_LEGACY_WIRE <= '0;
      O_PRDATA      <= 32'h0;
      O_PREADY      <= 1'b0;
      O_PSLVERR     <= 1'b0;
      O_DEC         <= '0;
      O_RSP         <= '0;
    end else begin
      for (int p = 0; p < N; p++) begin
        bus_reg[p]  <= next_bus[p];
        ctrl_reg[p] <= next_ctrl[p];
        stat[p]     <= next_stat[p];
      end
      gen           <= next_gen;
      wake          <= next_wake;
      lwst          <= next_lwst;
      O_LINK_WAKE   <= next_wake;
      O_LEGACY_WIRE <= next_lw_out;
      O_PRDATA      <= next_prdata;
      O_PREADY      <= next_pready;
      O_PSLVERR     <= next_pslverr;
      O_DEC         <= rd;
      O_RSP         <= next_rsp;
    end
  end

endmodule

// ==== scmr_router_properties.sv ====
// Concurrent checks on the decision, response and wake ports of the router.
// Assumes one I_CLK_SYS domain and I_RST_B active low; bound below.
`timescale 1ns/1ps
module scmr_router_properties (
  input wire logic                 I_CLK_SYS,
  input wire logic                 I_RST_B,
  input wire scmr_pkg::scmr_req_t  I_REQ,
  input wire scmr_pkg::scmr_dec_t  O_DEC,
  input wire scmr_pkg::scmr_rsp_t  I_RSP,
  input wire scmr_pkg::scmr_rspo_t O_RSP,
  input wire logic [3:0]           O_LINK_WAKE
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_B);

  // Type 0 requests never leave the ingress port
  a_type0_cfg_local: assert property (I_REQ.valid && I_REQ.kind == scmr_pkg::K_CFG0 |=> O_DEC.valid &&
    O_DEC.act inside {scmr_pkg::A_ACCESS, scmr_pkg::A_MABORT, scmr_pkg::A_REJECT})
    else $error("type 0 config left its port");
  a_type1_not_msg: assert property (I_REQ.valid && I_REQ.kind == scmr_pkg::K_CFG1 |=> O_DEC.valid &&
    !(O_DEC.act inside {scmr_pkg::A_DROP, scmr_pkg::A_DELIVER}))
    else $error("config request handled as message");
  a_msg_no_regs: assert property (I_REQ.valid && I_REQ.kind inside {scmr_pkg::K_MSG0, scmr_pkg::K_MSG1}
    |=> O_DEC.valid && !(O_DEC.act inside {scmr_pkg::A_ACCESS, scmr_pkg::A_MABORT, scmr_pkg::A_ONES}))
    else $error("message reached registers");
  a_intr_routed: assert property (I_REQ.valid && I_REQ.kind == scmr_pkg::K_INTR |=> O_DEC.valid &&
    O_DEC.act inside {scmr_pkg::A_FORWARD, scmr_pkg::A_REJECT, scmr_pkg::A_DROP})
    else $error("interrupt not forwarded");
  a_interrupt_acknowledge_request_routed: assert property (I_REQ.valid && I_REQ.kind == scmr_pkg::K_INTERRUPT_ACKNOWLEDGE_REQUEST |=> O_DEC.valid &&
    O_DEC.act inside {scmr_pkg::A_FORWARD, scmr_pkg::A_REJECT, scmr_pkg::A_DROP})
    else $error("acknowledge not forwarded");
  a_irq_on_drop: assert property (O_DEC.valid && (O_DEC.flood || O_DEC.fatal_irq || O_DEC.nonfatal_irq)
    |-> O_DEC.act == scmr_pkg::A_DROP && $onehot({O_DEC.flood, O_DEC.fatal_irq, O_DEC.nonfatal_irq}))
    else $error("error action without single drop");
  a_type0_convert: assert property (O_DEC.valid && O_DEC.to_type0 |->
    O_DEC.act inside {scmr_pkg::A_FORWARD, scmr_pkg::A_REFLECT, scmr_pkg::A_REJECT})
    else $error("type 0 conversion on local action");
  a_rsp_next: assert property (I_RSP.valid |=> O_RSP.valid && O_RSP.port == $past(I_RSP.port))
    else $error("response not passed next cycle");
  a_wake_cause: assert property ((|(O_LINK_WAKE & ~$past(O_LINK_WAKE))) |->
    (O_DEC.valid && O_DEC.act == scmr_pkg::A_FORWARD) || $past(O_DEC.valid && O_DEC.act == scmr_pkg::A_FORWARD))
    else $error("wake raised without forward");
endmodule

bind scmr_router scmr_router_properties scmr_router_properties_i (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_B(I_RST_B), .I_REQ(I_REQ), .O_DEC(O_DEC),
  .I_RSP(I_RSP), .O_RSP(O_RSP), .O_LINK_WAKE(O_LINK_WAKE));

// ==== scmr_router_tb.sv ====
// Self-checking bench for the routing core: APB set-up, packet decisions,
// wake, isolation. Assumes scmr_pkg and the link partner model are compiled.
`timescale 1ns/1ps
module scmr_router_tb;
  logic                 clk = 1'b0;
  logic                 rst_b = 1'b0;
  logic                 psel = 1'b0;
  logic                 penable = 1'b0;
  logic                 pwrite = 1'b0;
  logic [7:0]           paddr = 8'h00;
  logic [31:0]          pwdata = 32'h0;
  logic [31:0]          prdata;
  logic                 pready;
  logic                 pslverr;
  logic [31:0]          rdata;
  logic                 slverr;
  scmr_pkg::scmr_req_t  req = '0;
  scmr_pkg::scmr_dec_t  dec;
  scmr_pkg::scmr_dec_t  got;
  scmr_pkg::scmr_rsp_t  rsp;
  scmr_pkg::scmr_rspo_t rspo;
  logic [3:0]           stop = 4'h0;
  logic [3:0]           inact = 4'h0;
  logic [3:0]           local_fn = 4'hf;
  logic [3:0]           wake;
  logic [3:0][3:0]      legacy;
  logic [7:0]           rsp_delay = 8'h00;
  logic                 lw = 1'b0;
  logic [1:0]           lw_idx = 2'h0;
  logic                 lw_lvl = 1'b0;
  int                   miscompares = 0;
  int                   compares = 0;
  int                   cycles = 0;
  localparam scmr_pkg::scmr_kind_t cfg0 = scmr_pkg::K_CFG0, cfg1 = scmr_pkg::K_CFG1;
  localparam scmr_pkg::scmr_act_t fwd = scmr_pkg::A_FORWARD, acc = scmr_pkg::A_ACCESS, mabort = scmr_pkg::A_MABORT,
                                  refl = scmr_pkg::A_REFLECT;

  // Free-running 200 MHz clock
  always #2.5 clk = ~clk;

  scmr_router scmr_router_i (
    .I_CLK_SYS(clk), .I_RST_B(rst_b), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_REQ(req), .O_DEC(dec), .I_RSP(rsp), .O_RSP(rspo), .I_LINK_STOP(stop),
    .I_PORT_INACTIVE(inact), .I_LOCAL_FN(local_fn), .O_LINK_WAKE(wake), .O_LEGACY_WIRE(legacy));

  scmr_link_partner scmr_link_partner_i (
    .i_clk(clk), .i_rst_b(rst_b), .i_dec(dec), .i_delay(rsp_delay), .o_rsp(rsp));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic print_verdict;
    if (miscompares == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // APB transfer; the bench timeout is the only limit on the wait
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rdata = prdata;
    slverr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check("prdata", rdata, exp);
  endtask

  // Egress checked for routed actions only, conversion for forward or reflect
  task automatic send(input logic [1:0] p, input scmr_pkg::scmr_kind_t k, input logic [7:0] b,
                      input logic [4:0] d, input scmr_pkg::scmr_act_t a, input logic [1:0] ep, input logic t0);
    logic routed;
    logic typed;
    routed = a inside {scmr_pkg::A_ACCESS, scmr_pkg::A_FORWARD, scmr_pkg::A_REFLECT, scmr_pkg::A_DELIVER,
                       scmr_pkg::A_REJECT};
    typed = a inside {scmr_pkg::A_FORWARD, scmr_pkg::A_REFLECT};
    @(posedge clk);
    req <= '{1'b1, p, k, b, d, lw, lw_idx, lw_lvl};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    got = dec;
    check("decision", {got.valid, got.act, routed ? got.port : 2'h0, typed ? got.to_type0 : 1'b0},
          {1'b1, a, routed ? ep : 2'h0, typed ? t0 : 1'b0});
  endtask

  task automatic wait_rsp(input logic [1:0] ep, input logic drop);
    for (int i = 0; i < 200 && rspo.valid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    check("response", {rspo.valid, rspo.port, rspo.drop}, {1'b1, ep, drop});
  endtask

  // Hang guard, well above the run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict;
    end
  end

  // Main sequence; only defined packet directions are sent
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    for (int p = 0; p < 4; p++) begin
      rd({p[1:0], 4'h0}, 32'h0);
      rd({p[1:0], 4'h4}, 32'h0000_f000);
      rd({p[1:0], 4'h8}, 32'h0);
    end
    apb(1'b0, 8'h4c, 32'h0);
    check("slverr", {31'h0, slverr}, 32'h1);
    apb(1'b1, 8'h0c, 32'hffff_ffff);
    check("slverr", {31'h0, slverr}, 32'h1);
    // Port 0 primary over buses 1..32, ports 1..3 secondary below it
    apb(1'b1, 8'h00, 32'h0020_0100);
    apb(1'b1, 8'h04, 32'h0000_fc80);
    apb(1'b1, 8'h10, 32'h0105_0201);
    apb(1'b1, 8'h14, 32'h0000_f002);
    apb(1'b1, 8'h20, 32'h0209_0601);
    apb(1'b1, 8'h30, 32'h030c_0a01);
    rd(8'h30, 32'h030c_0a01);
    send(2'h0, cfg0, 8'h00, 5'h00, acc, 2'h0, 1'b0);
    send(2'h0, cfg0, 8'h00, 5'h05, mabort, 2'h0, 1'b0);
    send(2'h0, cfg1, 8'h21, 5'h00, mabort, 2'h0, 1'b0);
    send(2'h0, cfg1, 8'h01, 5'h02, acc, 2'h2, 1'b0);
    send(2'h0, cfg1, 8'h02, 5'h00, fwd, 2'h1, 1'b1);
    send(2'h0, cfg1, 8'h05, 5'h00, fwd, 2'h1, 1'b0);
    send(2'h0, cfg1, 8'h01, 5'h09, scmr_pkg::A_ONES, 2'h0, 1'b0);
    rd(8'h08, 32'h0000_0002);
    apb(1'b1, 8'h08, 32'h0000_003f);
    apb(1'b1, 8'h04, 32'h0000_fc84);
    send(2'h0, cfg1, 8'h01, 5'h09, scmr_pkg::A_TABORT, 2'h0, 1'b0);
    send(2'h0, scmr_pkg::K_MSG0, 8'h00, 5'h00, scmr_pkg::A_DELIVER, 2'h0, 1'b0);
    send(2'h0, scmr_pkg::K_MSG0, 8'h00, 5'h05, scmr_pkg::A_DROP, 2'h0, 1'b0);
    send(2'h0, scmr_pkg::K_MSG1, 8'h30, 5'h00, scmr_pkg::A_DROP, 2'h0, 1'b0);
    rd(8'h08, 32'h0000_0026);
    send(2'h0, scmr_pkg::K_INTERRUPT_ACKNOWLEDGE_REQUEST, 8'h00, 5'h00, fwd, 2'h3, 1'b0);
    // Upstream traffic entering on secondary ports 1, 2 and 3
    send(2'h1, cfg0, 8'h00, 5'h01, acc, 2'h1, 1'b0);
    send(2'h1, cfg0, 8'h00, 5'h02, mabort, 2'h0, 1'b0);
    send(2'h1, cfg1, 8'h02, 5'h01, acc, 2'h1, 1'b0);
    send(2'h1, cfg1, 8'h02, 5'h04, refl, 2'h1, 1'b1);
    send(2'h1, cfg1, 8'h04, 5'h00, refl, 2'h1, 1'b0);
    send(2'h1, cfg1, 8'h01, 5'h03, acc, 2'h3, 1'b0);
    send(2'h1, cfg1, 8'h40, 5'h00, fwd, 2'h0, 1'b0);
    send(2'h1, cfg1, 8'h06, 5'h00, fwd, 2'h2, 1'b1);
    send(2'h1, cfg1, 8'h07, 5'h00, fwd, 2'h2, 1'b0);
    send(2'h1, cfg1, 8'h0d, 5'h00, scmr_pkg::A_ONES, 2'h0, 1'b0);
    send(2'h1, scmr_pkg::K_MSG1, 8'h02, 5'h01, refl, 2'h1, 1'b1);
    send(2'h1, scmr_pkg::K_MSG1, 8'h40, 5'h00, fwd, 2'h0, 1'b0);
    send(2'h2, scmr_pkg::K_INTR, 8'h00, 5'h00, fwd, 2'h0, 1'b0);
    lw = 1'b1;
    lw_idx = 2'h2;
    lw_lvl = 1'b1;
    send(2'h3, scmr_pkg::K_SMGT, 8'h00, 5'h00, fwd, 2'h0, 1'b0);
    lw = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    check("legacy", {31'h0, legacy[0][2]}, 32'h1);
    // Hidden port, then upstream config disallowed with abort select on
    apb(1'b1, 8'h14, 32'h0000_f003);
    send(2'h1, cfg0, 8'h00, 5'h01, mabort, 2'h0, 1'b0);
    send(2'h1, cfg1, 8'h02, 5'h01, refl, 2'h1, 1'b1);
    apb(1'b1, 8'h14, 32'h0000_f04c);
    send(2'h1, cfg0, 8'h00, 5'h01, mabort, 2'h0, 1'b0);
    send(2'h1, cfg1, 8'h0d, 5'h00, scmr_pkg::A_TABORT, 2'h0, 1'b0);
    send(2'h1, scmr_pkg::K_MSG1, 8'h0d, 5'h00, scmr_pkg::A_DROP, 2'h0, 1'b0);
    check("error_action", {got.flood, got.fatal_irq, got.nonfatal_irq}, 32'h4);
    rd(8'h18, 32'h0000_0019);
    apb(1'b1, 8'h14, 32'h0000_f01c);
    send(2'h1, scmr_pkg::K_MSG1, 8'h0d, 5'h00, scmr_pkg::A_DROP, 2'h0, 1'b0);
    check("error_action", {got.flood, got.fatal_irq, got.nonfatal_irq}, 32'h2);
    // Stopped link is woken by a forward and released with the stop
    stop <= 4'h2;
    repeat (4) @(posedge clk);
    send(2'h0, cfg1, 8'h03, 5'h00, fwd, 2'h1, 1'b0);
    repeat (2) @(posedge clk);
    #1;
    check("wake", {28'h0, wake}, 32'h2);
    stop <= 4'h0;
    repeat (5) @(posedge clk);
    #1;
    check("wake", {28'h0, wake}, 32'h0);
    // Slow answer outlives a reset of port 2 and must be dropped
    rsp_delay <= 8'd40;
    send(2'h0, cfg1, 8'h07, 5'h00, fwd, 2'h2, 1'b0);
    inact <= 4'h4;
    repeat (4) @(posedge clk);
    inact <= 4'h0;
    wait_rsp(2'h2, 1'b1);
    rsp_delay <= 8'h00;
    send(2'h0, cfg1, 8'h03, 5'h00, fwd, 2'h1, 1'b0);
    wait_rsp(2'h1, 1'b0);
    inact <= 4'h4;
    repeat (4) @(posedge clk);
    send(2'h0, cfg1, 8'h07, 5'h00, scmr_pkg::A_REJECT, 2'h2, 1'b0);
    inact <= 4'h0;
    repeat (4) @(posedge clk);
    print_verdict;
  end
endmodule
